// file: hdl/se_read_engine.v
`timescale 1ns/1ps
`include "se_defs.vh"
module se_read_engine (
   input  wire SYS_CLK_I,
   input  wire ARST_N_I,
   input  wire SCL_I,
   input  wire SDA_I,
   output wire SDA_O,
   output wire SDA_OE_O,
   output wire BUSY_O,
   output wire WR_PEND_O
);
   localparam ST_IDLE = 5'h01;
   localparam ST_RX   = 5'h02;
   localparam ST_ACK  = 5'h04;
   localparam ST_TX   = 5'h08;
   localparam ST_RACK = 5'h10;

   localparam K_DEV   = 2'h0;
   localparam K_WADR  = 2'h1;
   localparam K_DATA  = 2'h2;

   reg  [7:0]                 mem [0:`SE_MEM_DEPTH-1];

   reg                        scl_s1_ff;
   reg                        scl_s2_ff;
   reg                        scl_s3_ff;
   reg                        sda_s1_ff;
   reg                        sda_s2_ff;
   reg                        sda_s3_ff;

   reg  [4:0]                 state_ff;
   reg  [4:0]                 nxt_state;
   reg  [1:0]                 kind_ff;
   reg  [1:0]                 nxt_kind;
   reg  [3:0]                 bitcnt_ff;
   reg  [3:0]                 nxt_bitcnt;
   reg  [7:0]                 rx_sh_ff;
   reg  [7:0]                 nxt_rx_sh;
   reg  [7:0]                 tx_sh_ff;
   reg  [7:0]                 nxt_tx_sh;
   reg  [`SE_ADDR_W-1:0]      addr_ff;
   reg  [`SE_ADDR_W-1:0]      nxt_addr;
   reg                        rd_ff;
   reg                        nxt_rd;
   reg                        drive_ff;
   reg                        nxt_drive;
   reg                        mack_ff;
   reg                        nxt_mack;
   reg                        busy_ff;
   reg                        push;

   wire                       scl_rise;
   wire                       scl_fall;
   wire                       start_det;
   wire                       stop_det;
   wire [7:0]                 rd_byte;
   wire                       fifo_in_ready;
   wire                       fifo_out_valid;
   wire                       fifo_pop;
   wire [`SE_WENTRY_W-1:0]    fifo_out_data;

   // read side walks the whole array, plain binary wrap
   function [`SE_ADDR_W-1:0] inc_read;
      input [`SE_ADDR_W-1:0] a;
      begin
         inc_read = a + {{(`SE_ADDR_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // write side only counts inside the page
   function [`SE_ADDR_W-1:0] inc_write;
      input [`SE_ADDR_W-1:0] a;
      begin
         inc_write = {a[`SE_ADDR_W-1:`SE_PAGE_LSB_W],
                      a[`SE_PAGE_LSB_W-1:0] + {{(`SE_PAGE_LSB_W-1){1'b0}}, 1'b1}};
      end
   endfunction

   // pins are asynchronous to the system clock: two stages, the third only for edges
   always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_s3_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_s3_ff <= 1'b1;
      end else begin
         scl_s1_ff <= SCL_I;
         scl_s2_ff <= scl_s1_ff;
         scl_s3_ff <= scl_s2_ff;
         sda_s1_ff <= SDA_I;
         sda_s2_ff <= sda_s1_ff;
         sda_s3_ff <= sda_s2_ff;
      end
   end

   assign scl_rise  = scl_s2_ff & ~scl_s3_ff;
   assign scl_fall  = ~scl_s2_ff & scl_s3_ff;
   assign start_det = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
   assign stop_det  = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
   assign rd_byte   = mem[addr_ff];

   always @* begin
      nxt_state  = state_ff;
      nxt_kind   = kind_ff;
      nxt_bitcnt = bitcnt_ff;
      nxt_rx_sh  = rx_sh_ff;
      nxt_tx_sh  = tx_sh_ff;
      nxt_addr   = addr_ff;
      nxt_rd     = rd_ff;
      nxt_drive  = drive_ff;
      nxt_mack   = mack_ff;
      push       = 1'b0;
      if (stop_det) begin
         nxt_state = ST_IDLE;
         nxt_drive = 1'b0;
      end else if (start_det) begin
         nxt_state  = ST_RX;
         nxt_kind   = K_DEV;
         nxt_bitcnt = 4'h0;
         nxt_drive  = 1'b0;
      end else begin
         case (state_ff)
            ST_RX: begin
               if (scl_rise) begin
                  nxt_rx_sh  = {rx_sh_ff[6:0], sda_s2_ff};
                  nxt_bitcnt = bitcnt_ff + 4'h1;
               end else if (scl_fall && bitcnt_ff == `SE_BYTE_BITS) begin
                  case (kind_ff)
                     K_DEV: begin
                        if (rx_sh_ff[7:4] == `SE_DEV_CODE) begin
                           nxt_state = ST_ACK;
                           nxt_drive = 1'b1;
                           nxt_rd    = rx_sh_ff[0];
                           if (!rx_sh_ff[0]) begin
                              nxt_addr[`SE_ADDR_W-1:8] = rx_sh_ff[2:1];
                           end
                        end else begin
                           nxt_state = ST_IDLE;
                        end
                     end
                     K_WADR: begin
                        nxt_state     = ST_ACK;
                        nxt_drive     = 1'b1;
                        nxt_addr[7:0] = rx_sh_ff;
                     end
                     default: begin
                        // a full buffer refuses the byte with no ack rather than lose it
                        if (fifo_in_ready) begin
                           push      = 1'b1;
                           nxt_state = ST_ACK;
                           nxt_drive = 1'b1;
                           nxt_addr  = inc_write(addr_ff);
                        end else begin
                           nxt_state = ST_IDLE;
                        end
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  nxt_drive  = 1'b0;
                  nxt_bitcnt = 4'h0;
                  if (rd_ff) begin
                     nxt_tx_sh = rd_byte;
                     nxt_drive = ~rd_byte[7];
                     nxt_addr  = inc_read(addr_ff);
                     nxt_state = ST_TX;
                  end else begin
                     nxt_state = ST_RX;
                     nxt_kind  = (kind_ff == K_DEV) ? K_WADR : K_DATA;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bitcnt_ff == `SE_LAST_BIT) begin
                     nxt_state = ST_RACK;
                     nxt_drive = 1'b0;
                  end else begin
                     nxt_tx_sh  = {tx_sh_ff[6:0], 1'b0};
                     nxt_drive  = ~tx_sh_ff[6];
                     nxt_bitcnt = bitcnt_ff + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  nxt_mack = ~sda_s2_ff;
               end else if (scl_fall) begin
                  nxt_bitcnt = 4'h0;
                  if (mack_ff) begin
                     nxt_tx_sh = rd_byte;
                     nxt_drive = ~rd_byte[7];
                     nxt_addr  = inc_read(addr_ff);
                     nxt_state = ST_TX;
                  end else begin
                     nxt_state = ST_IDLE;
                  end
               end
            end
            ST_IDLE: begin
               nxt_drive = 1'b0;
            end
            default: begin
               nxt_state = ST_IDLE;
               nxt_drive = 1'b0;
            end
         endcase
      end
   end

   always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_ff  <= ST_IDLE;
         kind_ff   <= K_DEV;
         bitcnt_ff <= 4'h0;
         rx_sh_ff  <= 8'h00;
         tx_sh_ff  <= 8'h00;
         addr_ff   <= `SE_ADDR_RST;
         rd_ff     <= 1'b0;
         drive_ff  <= 1'b0;
         mack_ff   <= 1'b0;
         busy_ff   <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         kind_ff   <= nxt_kind;
         bitcnt_ff <= nxt_bitcnt;
         rx_sh_ff  <= nxt_rx_sh;
         tx_sh_ff  <= nxt_tx_sh;
         addr_ff   <= nxt_addr;
         rd_ff     <= nxt_rd;
         drive_ff  <= nxt_drive;
         mack_ff   <= nxt_mack;
         busy_ff   <= (nxt_state != ST_IDLE);
      end
   end

   // buffered bytes reach the array only while the engine is in ST_IDLE, so a page burst can fill it
   assign fifo_pop = fifo_out_valid & (state_ff == ST_IDLE);

   always @(posedge SYS_CLK_I) begin
      if (fifo_pop) begin
         mem[fifo_out_data[`SE_WENTRY_W-1:8]] <= fifo_out_data[7:0];
      end
   end

   se_fifo #(
      .W     (`SE_WENTRY_W),
      .DEPTH (`SE_FIFO_DEPTH),
      .AW    (`SE_FIFO_AW)
   ) u_wbuf (
      .clk_i       (SYS_CLK_I),
      .arst_n_i    (ARST_N_I),
      .in_valid_i  (push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({addr_ff, rx_sh_ff}),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (state_ff == ST_IDLE),
      .out_data_o  (fifo_out_data)
   );

   // open drain: only ever pulls low
   assign SDA_O     = 1'b0;
   assign SDA_OE_O  = drive_ff;
   assign BUSY_O    = busy_ff;
   assign WR_PEND_O = fifo_out_valid;
endmodule

// file: hdl/se_defs.vh
// Operation
// - word address counter holds last accessed address plus one, kept between transfers
// - read increments wrap from the last array byte to the first
// - write increments wrap inside the current page, page bits unchanged
// - after acking a read address byte, the byte at the counter is shifted out
// - random read starts with a dummy write whose word address loads the counter
// - each master acknowledge makes the device increment and send the next byte
// - sequential read wraps at the top of the array and carries on
// - master no-acknowledge plus stop ends the read; device releases the data line
// - bytes are eight bits, receiver pulls data low on the ninth clock
// - start is data falling with clock high, stop is data rising with clock high
// - ten-bit word address, top bits taken from page bits of a write address byte; a read address byte leaves them unchanged
// - ack the address byte only on a code match, else ignore until next start
`ifndef SE_DEFS_VH
`define SE_DEFS_VH
`define SE_ADDR_W      10
`define SE_MEM_DEPTH   1024
`define SE_PAGE_LSB_W  4
`define SE_DEV_CODE    4'ha
`define SE_BYTE_BITS   4'h8
`define SE_LAST_BIT    4'h7
`define SE_FIFO_DEPTH  4
`define SE_FIFO_AW     2
`define SE_WENTRY_W    18
`define SE_ADDR_RST    10'h000
`endif

// file: hdl/se_fifo.v
`timescale 1ns/1ps
module se_fifo #(
   parameter W     = 18,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire         clk_i,
   input  wire         arst_n_i,
   input  wire         in_valid_i,
   output wire         in_ready_o,
   input  wire [W-1:0] in_data_i,
   output wire         out_valid_o,
   input  wire         out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0]  mem [0:DEPTH-1];
   reg [AW-1:0] wp_ff;
   reg [AW-1:0] rp_ff;
   reg [AW:0]   cnt_ff;
   wire         do_push;
   wire         do_pop;

   assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
   assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
   assign out_data_o  = mem[rp_ff];
   assign do_push     = in_valid_i & in_ready_o;
   assign do_pop      = out_valid_o & out_ready_i;

   always @(posedge clk_i) begin
      if (do_push) begin
         mem[wp_ff] <= in_data_i;
      end
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wp_ff  <= {AW{1'b0}};
         rp_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end else begin
         if (do_push) begin
            wp_ff <= wp_ff + {{(AW-1){1'b0}}, 1'b1};
         end
         if (do_pop) begin
            rp_ff <= rp_ff + {{(AW-1){1'b0}}, 1'b1};
         end
         if (do_push && !do_pop) begin
            cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
         end else if (do_pop && !do_push) begin
            cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

// file: tb/se_read_engine_assertions.sv
`timescale 1ns/1ps
module se_read_engine_assertions (
   input wire SYS_CLK_I,
   input wire ARST_N_I,
   input wire SCL_I,
   input wire SDA_I,
   input wire SDA_O,
   input wire SDA_OE_O,
   input wire BUSY_O,
   input wire WR_PEND_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   chk_data_value_low: assert property (SDA_O == 1'b0)
      else $error("data value not low");
   chk_drive_needs_busy: assert property (SDA_OE_O |-> BUSY_O)
      else $error("drive while engine idle");
   // the device may only move the line while the clock is low
   chk_drive_clock_low: assert property ($rose(SDA_OE_O) |-> !$past(SCL_I, 2))
      else $error("drive rose with clock high");
   chk_drive_stable_high: assert property (
      SCL_I && $past(SCL_I) |-> $stable(SDA_OE_O))
      else $error("drive moved with clock high");
   chk_drive_holds_bit: assert property ($rose(SDA_OE_O) |-> SDA_OE_O [*6])
      else $error("drive shorter than a bit");
   chk_release_holds_bit: assert property ($fell(SDA_OE_O) |-> !SDA_OE_O [*6])
      else $error("release shorter than a bit");
   chk_idle_release: assert property ($fell(BUSY_O) |-> !SDA_OE_O [*8])
      else $error("drive while idle");
   chk_stop_idle: assert property (
      SCL_I && $rose(SDA_I) |-> ##[1:6] (!BUSY_O && !SDA_OE_O))
      else $error("stop not seen");
   chk_start_busy: assert property (SCL_I && $fell(SDA_I) |-> ##[1:6] BUSY_O)
      else $error("start not seen");
   chk_buffer_drain: assert property (WR_PEND_O && !BUSY_O |-> ##[1:6] !WR_PEND_O)
      else $error("buffer not drained");
   cov_drive: cover property ($rose(SDA_OE_O));
   cov_idle: cover property ($fell(BUSY_O));
   cov_pend: cover property ($rose(WR_PEND_O));
endmodule
bind se_read_engine se_read_engine_assertions se_read_engine_assertions_i (
   .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
   .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .BUSY_O(BUSY_O), .WR_PEND_O(WR_PEND_O));

// file: tb/se_master.sv
`timescale 1ns/1ps
module se_master (
   input  wire  clk_i,
   input  wire  sda_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // clock stands high between frames; also serves as repeated start
   task automatic start();
      tick(1);
      sda_o = 1'b1;
      // the device may still pull its ack for a few cycles; let the line rise before the clock
      tick(4);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b0;
      tick(4);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      tick(1);
      sda_o = 1'b0;
      tick(2);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b1;
      tick(4);
   endtask
   // low phase of 5 leaves room for the device's late drive change
   task automatic bit_io(input logic b, output logic r);
      tick(1);
      sda_o = b;
      tick(4);
      scl_o = 1'b1;
      tick(2);
      r = sda_i;
      tick(1);
      scl_o = 1'b0;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic recv(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(~ack, r);
   endtask
endmodule

// file: tb/se_read_engine_tb.sv
`timescale 1ns/1ps
`include "se_defs.vh"
module se_read_engine_tb;
   logic clk;
   logic arst_n;
   logic scl;
   logic sda_m;
   logic oe;
   logic sdo;
   logic busy;
   logic wpend;
   wire  sda_w = sda_m & ~oe;
   int   failures = 0;
   int   comparisons = 0;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   se_read_engine se_read_engine_i (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .SCL_I(scl),
      .SDA_I(sda_w), .SDA_O(sdo), .SDA_OE_O(oe), .BUSY_O(busy), .WR_PEND_O(wpend));
   se_master se_master_i (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
   function automatic logic [7:0] pat(input logic [9:0] a);
      return a[7:0] ^ {a[9:8], 6'h15};
   endfunction
   task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // targets are page-wrapped here, independent of the device
   task automatic wr_page(input logic [1:0] pg, input logic [7:0] wd, input int n);
      logic ack;
      se_master_i.start();
      se_master_i.send({`SE_DEV_CODE, 1'b0, pg, 1'b0}, ack);
      cmp(10'(ack), 10'h1);
      se_master_i.send(wd, ack);
      cmp(10'(ack), 10'h1);
      for (int i = 0; i < n; i++) begin
         se_master_i.send(pat({pg, wd[7:4], wd[3:0] + 4'(i)}), ack);
         cmp(10'(ack), 10'h1);
      end
      se_master_i.stop();
      for (int k = 0; k < 50 && wpend !== 1'b0; k++) begin
         @(posedge clk);
         #1;
      end
      cmp(10'(wpend), 10'h0);
   endtask
   task automatic rd_seq(input logic rnd, input logic [9:0] a0, input int n);
      logic ack;
      logic [7:0] d;
      se_master_i.start();
      if (rnd) begin
         se_master_i.send({`SE_DEV_CODE, 1'b0, a0[9:8], 1'b0}, ack);
         se_master_i.send(a0[7:0], ack);
         cmp(10'(ack), 10'h1);
         se_master_i.start();
      end
      se_master_i.send({`SE_DEV_CODE, 4'h1}, ack);
      cmp(10'(ack), 10'h1);
      for (int i = 0; i < n; i++) begin
         se_master_i.recv(i < n - 1, d);
         cmp(10'(d), 10'(pat(a0 + 10'(i))));
      end
      se_master_i.stop();
      cmp(10'({busy, oe}), 10'h0);
   endtask
   task automatic bad_code();
      logic ack;
      se_master_i.start();
      se_master_i.send(8'h51, ack);
      cmp(10'(ack), 10'h0);
      se_master_i.send(8'ha1, ack);
      cmp(10'(ack), 10'h0);
      se_master_i.stop();
   endtask
   // a fifth byte in one transfer finds the buffer full and is refused
   task automatic full_buf();
      logic ack;
      se_master_i.start();
      se_master_i.send({`SE_DEV_CODE, 4'h0}, ack);
      se_master_i.send(8'h10, ack);
      cmp(10'(ack), 10'h1);
      for (int i = 0; i < 5; i++) begin
         se_master_i.send(pat(10'h010 + 10'(i)), ack);
         cmp(10'(ack), 10'(i < 4));
      end
      se_master_i.stop();
      rd_seq(1'b1, 10'h010, 4);
   endtask
   initial begin
      arst_n = 1'b0;
      repeat (16) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      wr_page(2'h3, 8'hfe, 4);
      wr_page(2'h0, 8'h00, 2);
      rd_seq(1'b1, 10'h3fe, 3);
      rd_seq(1'b0, 10'h001, 1);
      rd_seq(1'b1, 10'h3f0, 1);
      bad_code();
      rd_seq(1'b0, 10'h3f1, 1);
      full_buf();
      conclude();
   end
   initial begin
      #500us;
      failures++;
      conclude();
   end
endmodule
